// ---- core/usp_cfg.svh ----
// Register offsets, field positions, reset values and timing of the serial port.
`ifndef USP_CFG_SVH
`define USP_CFG_SVH
`define CLK_HZ      250000000
`define CLK_NS      4
`define OVERSAMPLE  16
`define BPS_110     110
`define BPS_300     300
`define BPS_600     600
`define BPS_1200    1200
`define BPS_2400    2400
`define BPS_4800    4800
`define BPS_9600    9600
`define BPS_19200   19200
`define RATE_DEF    3'h6
`define RATE_FAST   3'h7
`define OFS_CFG     12'h000
`define OFS_STAT    12'h004
`define OFS_TXD     12'h008
`define OFS_RXD     12'h00c
`define CFG_RST     32'h0000_0000
`define F_BAUD      3:0
`define F_PAR       5:4
`define F_LEN7      6
`define F_STOP      9:8
`define F_FLOW      14:12
`define F_TXOFF     16
`define F_TERM_EN   17
`define F_TERM      31:24
`define S_TXBUSY    0
`define S_HOLD      1
`define S_RXVALID   2
`define S_PAUSED    3
`define S_TERM      4
`define S_OVERRUN   5
`define S_PERR      6
`define S_FERR      7
`define CHR_XON     8'h11
`define CHR_XOFF    8'h13
`endif

// ---- core/usp_pkg.sv ----
// Types shared by the serial port modules.
package usp_pkg;
	typedef enum logic [1:0] {par_none = 2'h0, par_even = 2'h1, par_odd = 2'h2} parity_t;
	typedef enum logic [2:0] {
		flow_none = 3'h0, flow_send = 3'h1, flow_recv = 3'h2, flow_both = 3'h3, flow_hw = 3'h4
	} flow_t;
	typedef enum logic [2:0] {
		st_idle = 3'h0, st_start = 3'h1, st_data = 3'h2, st_par = 3'h3, st_stop = 3'h4
	} bit_state_t;
endpackage

// ---- core/frame_cfg_if.sv ----
// Line settings carried from the port core to its shifters.
`timescale 1ns/10ps
`default_nettype none
interface frame_cfg_if;
	import usp_pkg::*;
	logic    tick;
	logic    data7;
	parity_t parity;
	logic    stop2;
	modport ctl  (output tick, data7, parity, stop2);
	modport port (input tick, data7, parity, stop2);
endinterface
`default_nettype wire

// ---- core/serial_tx.sv ----
// Character transmitter with optional parity and one or two stop bits.
`timescale 1ns/10ps
`default_nettype none
module serial_tx import usp_pkg::*; (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// Line settings.
	frame_cfg_if.port       cfg,
	// Character in.
	input  wire logic       start,
	input  wire logic [7:0] data,
	output logic            busy,
	// Serial line.
	output logic            txd
);
	bit_state_t state;
	bit_state_t next_state;
	logic [3:0] sub;
	logic [2:0] idx;
	logic [7:0] chr;
	logic       stop_cnt;

	// Bit timing and the level the line should carry.
	wire       bit_end  = cfg.tick && (sub == 4'hf);
	wire [2:0] last_idx = cfg.data7 ? 3'h6 : 3'h7;
	wire [7:0] mask     = cfg.data7 ? 8'h7f : 8'hff;
	wire       par_bit  = (cfg.parity == par_odd) ^ (^(chr & mask));
	wire       line_bit = (state == st_start) ? 1'b0 :
	                      (state == st_data)  ? chr[idx] :
	                      (state == st_par)   ? par_bit : 1'b1;
	assign busy = state != st_idle;

	// Frame sequence: start, data, optional parity, stop time.
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle:  if (start) next_state = st_start;
			st_start: if (bit_end) next_state = st_data;
			st_data:  if (bit_end && idx == last_idx) begin
				next_state = (cfg.parity == par_none) ? st_stop : st_par;
			end
			st_par:   if (bit_end) next_state = st_stop;
			st_stop:  if (bit_end && (stop_cnt || !cfg.stop2)) next_state = st_idle;
			default:  next_state = st_idle;
		endcase
	end

	// State and counters; the line is registered so it never glitches.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= st_idle;
			sub      <= 4'h0;
			idx      <= 3'h0;
			chr      <= 8'h00;
			stop_cnt <= 1'b0;
			txd      <= 1'b1;
		end else if (clk_en) begin
			state <= next_state;
			txd   <= line_bit;
			if (state == st_idle) begin
				sub      <= 4'h0;
				idx      <= 3'h0;
				stop_cnt <= 1'b0;
				if (start) chr <= data;
			end else if (cfg.tick) begin
				sub <= sub + 4'h1;
			end
			if (bit_end && state == st_data) idx <= idx + 3'h1;
			if (bit_end && state == st_stop) stop_cnt <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_tx_even_par: assert property (clk_en && state == st_par && cfg.parity == par_even
		|=> txd == ^(chr & mask)) else $error("even parity bit wrong");
	a_tx_odd_par: assert property (clk_en && state == st_par && cfg.parity == par_odd
		|=> txd == !(^(chr & mask))) else $error("odd parity bit wrong");
	a_tx_no_par: assert property (state == st_par |-> cfg.parity != par_none)
		else $error("parity sent while parity is off");
	a_tx_length: assert property (state == st_data |-> idx <= last_idx)
		else $error("too many data bits");
	a_tx_start_low: assert property (clk_en && state == st_start |=> !txd)
		else $error("start bit not low");
	a_tx_idle_high: assert property (clk_en && state == st_idle |=> txd)
		else $error("idle line not high");
endmodule
`default_nettype wire

// ---- core/serial_rx.sv ----
// Character receiver sampling each bit at its centre.
`timescale 1ns/10ps
`default_nettype none
module serial_rx import usp_pkg::*; (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// Line settings.
	frame_cfg_if.port       cfg,
	// Synchronised serial input.
	input  wire logic       rxd,
	// Received character.
	output logic            busy,
	output logic            done,
	output logic [7:0]      data,
	output logic            perr,
	output logic            ferr
);
	bit_state_t state;
	logic [3:0] sub;
	logic [2:0] idx;

	// Half a bit confirms the start; whole bits then land at bit centres.
	wire       mid     = cfg.tick && (sub == 4'h7);
	wire       bit_end = cfg.tick && (sub == 4'hf);
	wire       last    = idx == (cfg.data7 ? 3'h6 : 3'h7);
	wire [7:0] mask    = cfg.data7 ? 8'h7f : 8'hff;
	wire       par_exp = (cfg.parity == par_odd) ^ (^(data & mask));
	assign busy = state != st_idle;

	// Receive sequence; a high level at mid start bit is taken as noise.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			sub   <= 4'h0;
			idx   <= 3'h0;
			data  <= 8'h00;
			done  <= 1'b0;
			perr  <= 1'b0;
			ferr  <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (cfg.tick) sub <= sub + 4'h1;
			unique case (state)
				st_idle: begin
					sub <= 4'h0;
					idx <= 3'h0;
					if (!rxd) begin
						state <= st_start;
						data  <= 8'h00;
						perr  <= 1'b0;
					end
				end
				st_start: if (mid) begin
					sub   <= 4'h0;
					state <= rxd ? st_idle : st_data;
				end
				st_data: if (bit_end) begin
					data[idx] <= rxd;
					idx       <= idx + 3'h1;
					if (last) state <= (cfg.parity == par_none) ? st_stop : st_par;
				end
				st_par: if (bit_end) begin
					perr  <= rxd != par_exp;
					state <= st_stop;
				end
				st_stop: if (bit_end) begin
					ferr  <= !rxd;
					done  <= 1'b1;
					state <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_rx_start_seen: assert property (clk_en && state == st_idle && !rxd |=> state == st_start)
		else $error("start edge missed");
endmodule
`default_nettype wire

// ---- core/user_serial_port.sv ----
// Configurable asynchronous serial user port with APB registers and flow control.
//
// Summary of operation
// - Rates 110 to 19200 bit/s selectable; 9600 when the rate is omitted.
// - Rates above 9600 are accepted only together with hardware handshake.
// - Even parity: parity bit is one when data ones count is odd.
// - Odd parity: parity bit is one when data ones count is even.
// - No parity, the default, means no parity bit sent or checked.
// - Seven or eight data bits; eight by default.
// - One or two stop bits; two at 110 by default, else one.
// - Receive flow mode: XOFF received pauses sending, XON resumes it.
// - Send flow mode: send XOFF when input must stop, XON to resume.
// - Hardware mode: RTS and CTS throttle each end before any overrun.
// - Driver-off option releases the line driver when nothing is left to send.
// - Optional terminator character marks end of a data block; off by default.
// - An omitted setting takes its default; an all-empty setting gives all defaults.
`include "usp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module user_serial_port import usp_pkg::*; #(
	parameter int unsigned sys_clk_hz = `CLK_HZ
) (
	// Clock, clock enable and reset.
	input  wire logic        ref_clk,
	input  wire logic        clk_en,
	input  wire logic        reset_n,
	// APB register port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line and handshake.
	input  wire logic        rxd,
	input  wire logic        cts_n,
	output logic             txd,
	output logic             txd_oe_n,
	output logic             rts_n
);
	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	// A zero code means the setting was left out, so it picks the default.
	function automatic logic [2:0] rate_idx_of(input logic [3:0] code);
		rate_idx_of = (code == 4'h0 || code > 4'h8) ? `RATE_DEF : 3'(code - 4'h1);
	endfunction

	function automatic flow_t flow_of(input logic [2:0] code);
		flow_of = (code > 3'h4) ? flow_none : flow_t'(code);
	endfunction

	// Clock cycles per sixteenth of a bit; rounds down, so bits run slightly fast.
	function automatic logic [31:0] div_of(input logic [2:0] idx);
		unique case (idx)
			3'h0:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_110));
			3'h1:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_300));
			3'h2:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_600));
			3'h3:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_1200));
			3'h4:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_2400));
			3'h5:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_4800));
			3'h6:    div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_9600));
			default: div_of = 32'(sys_clk_hz / (`OVERSAMPLE * `BPS_19200));
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic       rst_n;
	logic [1:0] rxd_pipe;
	logic [1:0] cts_pipe;

	// Reset is asserted at once but released only after two clean edges.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_pipe <= 2'h0;
		end else if (clk_en) begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// Line inputs are asynchronous; only the second stage is ever read.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_pipe <= 2'h3;
			cts_pipe <= 2'h3;
		end else if (clk_en) begin
			rxd_pipe <= {rxd_pipe[0], rxd};
			cts_pipe <= {cts_pipe[0], cts_n};
		end
	end

	// ----------------------------------------------------------------
	// Settings register and line settings
	// ----------------------------------------------------------------
	logic [31:0] cfg;
	logic        stop2;
	parity_t     par;
	flow_t       flow;
	frame_cfg_if line_cfg();

	wire [2:0] rate_idx  = rate_idx_of(cfg[`F_BAUD]);
	wire [2:0] wr_rate   = rate_idx_of(pwdata[`F_BAUD]);
	wire       send_mode = flow == flow_send || flow == flow_both;
	wire       recv_mode = flow == flow_recv || flow == flow_both;
	wire       hw_mode   = flow == flow_hw;
	wire       term_en   = cfg[`F_TERM_EN];
	wire [7:0] term_chr  = cfg[`F_TERM];
	wire       drv_off   = cfg[`F_TXOFF];

	// Code 3 in the parity field is treated as the default; in the stop field it gives one stop bit.
	assign flow  = flow_of(cfg[`F_FLOW]);
	assign par   = (cfg[`F_PAR] == 2'h3) ? par_none : parity_t'(cfg[`F_PAR]);
	assign stop2 = (cfg[`F_STOP] == 2'h2) || (cfg[`F_STOP] == 2'h0 && rate_idx == 3'h0);

	assign line_cfg.data7  = cfg[`F_LEN7];
	assign line_cfg.parity = par;
	assign line_cfg.stop2  = stop2;

	// ----------------------------------------------------------------
	// Bit-rate tick
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt;
	logic        tick;

	// One tick per sixteenth of a bit, shared by both shifters.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end else if (clk_en) begin
			tick     <= tick_cnt >= div_of(rate_idx) - 32'h1;
			tick_cnt <= (tick_cnt >= div_of(rate_idx) - 32'h1) ? 32'h0 : tick_cnt + 32'h1;
		end
	end
	assign line_cfg.tick = tick;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic       hold_valid;
	logic [7:0] hold_data;
	logic       rx_valid;
	logic [7:0] rx_buf;
	logic       told_stop;
	logic       paused;
	logic [3:0] sticky;

	wire hit_cfg  = paddr == `OFS_CFG;
	wire hit_stat = paddr == `OFS_STAT;
	wire hit_txd  = paddr == `OFS_TXD;
	wire hit_rxd  = paddr == `OFS_RXD;
	wire mapped   = hit_cfg || hit_stat || hit_txd || hit_rxd;
	wire setup    = psel && !penable && clk_en;
	wire access   = psel && penable && clk_en;
	// A fast rate without hardware handshake is refused and keeps the old setting.
	wire cfg_bad  = pwrite && hit_cfg && wr_rate == `RATE_FAST
	                && flow_of(pwdata[`F_FLOW]) != flow_hw;
	wire txd_bad  = pwrite && hit_txd && hold_valid;
	wire wr_cfg   = access && pwrite && hit_cfg && !cfg_bad;
	wire wr_stat  = access && pwrite && hit_stat;
	wire wr_txd   = access && pwrite && hit_txd && !hold_valid;
	wire rd_rxd   = access && !pwrite && hit_rxd;

	// A frozen clock enable stretches the access phase.
	assign pready  = clk_en;
	assign pslverr = psel && penable && (!mapped || cfg_bad || txd_bad);

	// ----------------------------------------------------------------
	// Shifters
	// ----------------------------------------------------------------
	logic       tx_busy;
	logic       rx_busy;
	logic       rx_done;
	logic [7:0] rx_char;
	logic       rx_perr;
	logic       rx_ferr;

	wire       cts_ok    = !hw_mode || !cts_pipe[1];
	wire       flow_pend = send_mode && (rx_valid != told_stop);
	wire       data_ok   = hold_valid && !paused && cts_ok;
	wire       tx_start  = clk_en && !tx_busy && (flow_pend || data_ok);
	wire [7:0] tx_char   = flow_pend ? (rx_valid ? `CHR_XOFF : `CHR_XON) : hold_data;

	serial_tx u_tx (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.cfg     (line_cfg),
		.start   (tx_start),
		.data    (tx_char),
		.busy    (tx_busy),
		.txd     (txd)
	);

	serial_rx u_rx (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.cfg     (line_cfg),
		.rxd     (rxd_pipe[1]),
		.busy    (rx_busy),
		.done    (rx_done),
		.data    (rx_char),
		.perr    (rx_perr),
		.ferr    (rx_ferr)
	);

	// Flow characters are consumed in receive mode and never reach software.
	wire is_xoff  = rx_char == `CHR_XOFF;
	wire is_flow  = recv_mode && (is_xoff || rx_char == `CHR_XON);
	wire rx_store = rx_done && !is_flow;
	wire term_hit = rx_store && term_en && rx_char == term_chr;
	wire [3:0] sticky_set = {rx_store && rx_ferr, rx_store && rx_perr,
	                         rx_store && rx_valid && !rd_rxd, term_hit};

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Settings, transmit holding and receive holding.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg        <= `CFG_RST;
			hold_valid <= 1'b0;
			hold_data  <= 8'h00;
			rx_valid   <= 1'b0;
			rx_buf     <= 8'h00;
		end else if (clk_en) begin
			if (wr_cfg) cfg <= pwdata;
			if (wr_txd) hold_data <= pwdata[7:0];
			hold_valid <= wr_txd || (hold_valid && !(tx_start && !flow_pend));
			if (rx_store) rx_buf <= rx_char;
			rx_valid <= rx_store || (rx_valid && !rd_rxd);
		end
	end

	// Flow state and sticky status; a new event wins over its clear.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			told_stop <= 1'b0;
			paused    <= 1'b0;
			sticky    <= 4'h0;
		end else if (clk_en) begin
			if (!send_mode) told_stop <= 1'b0;
			else if (tx_start && flow_pend) told_stop <= rx_valid;
			if (!recv_mode) paused <= 1'b0;
			else if (rx_done && is_flow) paused <= is_xoff;
			sticky <= sticky_set | (sticky & ~(wr_stat ? pwdata[`S_FERR:`S_TERM] : 4'h0));
		end
	end

	// Read data is captured in the setup phase, looking past a same-cycle store.
	wire [7:0]  rx_view   = rx_store ? rx_char : rx_buf;
	wire [31:0] stat_word = {24'h0, sticky, paused, rx_valid, hold_valid, tx_busy};
	wire [31:0] rd_word   = hit_cfg  ? cfg :
	                        hit_stat ? stat_word :
	                        hit_rxd  ? {24'h0, rx_view} : 32'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Line driver and handshake
	// ----------------------------------------------------------------
	// The driver stays on while a character is queued, sent or owed.
	wire next_oe_n = drv_off && !(tx_busy || tx_start || hold_valid || flow_pend);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txd_oe_n <= 1'b0;
		end else if (clk_en) begin
			txd_oe_n <= next_oe_n;
		end
	end

	// RTS drops while a character is arriving, so the far end stops before overrun.
	assign rts_n = hw_mode && (rx_valid || rx_busy);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_rate_default: assert property (cfg[`F_BAUD] == 4'h0 |-> tick_cnt < div_of(3'h6))
		else $error("omitted rate is not 9600");
	a_fast_needs_hw: assert property (rate_idx == `RATE_FAST |-> hw_mode)
		else $error("fast rate without hardware handshake");
	a_stop_default: assert property (cfg[`F_STOP] == 2'h0 |-> stop2 == (rate_idx == 3'h0))
		else $error("default stop bit count wrong");
	a_xoff_pause: assert property (clk_en && rx_done && recv_mode && is_xoff
		|=> paused && !tx_start ##1 !tx_start) else $error("XOFF did not pause");
	a_xoff_send: assert property (send_mode && rx_valid && !told_stop && !tx_busy && clk_en
		|-> tx_start && tx_char == `CHR_XOFF) else $error("XOFF not sent");
	a_rts_throttle: assert property (hw_mode && (rx_valid || rx_busy) |-> rts_n)
		else $error("RTS left asserted while full");
	a_cts_hold: assert property (hw_mode && cts_pipe[1] |-> !tx_start)
		else $error("sent while CTS inactive");
	a_driver_off: assert property (clk_en && drv_off && !tx_busy && !hold_valid && !flow_pend
		|=> txd_oe_n) else $error("driver left on with nothing to send");
	a_term_flag: assert property (clk_en && term_hit |=> sticky[0])
		else $error("terminator not flagged");
	a_empty_defaults: assert property (wr_cfg && pwdata == 32'h0
		|=> rate_idx == `RATE_DEF && par == par_none && flow == flow_none && !stop2)
		else $error("empty settings not all defaults");

	c_flow_char: cover property (tx_start && flow_pend);
	c_term_rx: cover property (term_hit);
	c_refused: cover property (psel && penable && pslverr);
	c_hw_stall: cover property (hw_mode && hold_valid && cts_pipe[1]);
endmodule
`default_nettype wire

// ---- dv/serial_term.sv ----
// Behavioural serial terminal on the far side of the user serial port.
`timescale 1ns/10ps
`default_nettype none
module serial_term (
	// Clock and bit length in clock cycles.
	input  wire logic ref_clk,
	input  var  int   bit_cyc,
	// Serial lines and handshake.
	input  wire logic txd,
	input  wire logic txd_oe_n,
	input  wire logic rts_n,
	output var  logic rxd
);
	logic [10:0] frame;
	int          nframes = 0;

	// Fail-safe bias holds a released line high, so a driver that turns off
	// in mid-frame corrupts what the terminal sees.
	wire line = txd_oe_n ? 1'b1 : txd;

	// The idle line is high, as a pull-up would leave it.
	initial rxd = 1'b1;

	// ----------------------------------------------------------------
	// Frame capture
	// ----------------------------------------------------------------
	// Samples on the falling clock edge, so that registered outputs have settled.
	initial forever begin
		@(negedge line);
		repeat (bit_cyc / 2) @(negedge ref_clk);
		for (int i = 0; i < 11; i++) begin
			frame[i] = line;
			if (i < 10) repeat (bit_cyc) @(negedge ref_clk);
		end
		nframes++;
	end

	// Sends one 8N1 character, low start bit first, data LSB first.
	// It first waits, for a bounded time, while the port holds RTS off.
	task send(input logic [7:0] d);
		for (int i = 0; i < 2000 && rts_n; i++) @(posedge ref_clk);
		@(posedge ref_clk);
		rxd <= 1'b0;
		repeat (bit_cyc) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rxd <= d[i];
			repeat (bit_cyc) @(posedge ref_clk);
		end
		rxd <= 1'b1;
		repeat (bit_cyc) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ---- dv/user_serial_port_bench.sv ----
// Self-checking bench of the user serial port over APB and the serial line.
`include "usp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module user_serial_port_bench import usp_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        cts_n = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready, pslverr, e, txd, txd_oe_n, rts_n, rxd;
	int          bit_cyc = 64;
	int          miscompares = 0;
	int          n_checks = 0;
	int          nf;

	// A low system clock keeps frames short: 9600 bit/s gives 64 cycles a bit.
	user_serial_port #(.sys_clk_hz(614400)) user_serial_port_i (.ref_clk(ref_clk),
		.clk_en(1'b1), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .cts_n(cts_n), .txd(txd), .txd_oe_n(txd_oe_n), .rts_n(rts_n));
	serial_term serial_term_i (.ref_clk(ref_clk), .bit_cyc(bit_cyc), .txd(txd),
		.txd_oe_n(txd_oe_n), .rts_n(rts_n), .rxd(rxd));

	initial forever #2 ref_clk = ~ref_clk;

	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task check(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin miscompares++; finish_test; end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_frame;
		int i;
		for (i = 0; i < 3000 && serial_term_i.nframes == nf; i++) @(posedge ref_clk);
		if (i == 3000) begin miscompares++; finish_test; end
		nf = serial_term_i.nframes;
	endtask

	// Polls a status bit until it reads the wanted value.
	task poll(input int b, input logic v);
		int i;
		for (i = 0; i < 500; i++) begin
			apb(1'b0, `OFS_STAT, 32'h0);
			if (q[b] === v) break;
		end
		check(q[b], v);
	endtask

	// Expected line bits from the start bit on, idle high after the stop bit.
	function automatic logic [10:0] frm(input logic [7:0] d, input logic l7,
			input logic [1:0] p);
		logic [10:0] f;
		logic        x;
		int          n;
		f = '1;
		f[0] = 1'b0;
		n = l7 ? 7 : 8;
		x = 1'b0;
		for (int i = 0; i < n; i++) begin
			f[i + 1] = d[i];
			x ^= d[i];
		end
		if (p == 2'h1) f[n + 1] = x;
		else if (p == 2'h2) f[n + 1] = ~x;
		return f;
	endfunction

	task send_chk(input logic [7:0] d, input logic l7, input logic [1:0] p);
		apb(1'b1, `OFS_TXD, {24'h0, d});
		check(e, 1'b0);
		wait_frame;
		check(serial_term_i.frame, frm(d, l7, p));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		check(txd, 1'b1);
		apb(1'b0, `OFS_CFG, 32'h0);
		check(q, `CFG_RST);
		apb(1'b0, `OFS_STAT, 32'h0);
		check(q, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check(e, 1'b1);
		nf = serial_term_i.nframes;
		send_chk(8'ha5, 1'b0, 2'h0);
		// Even then odd parity, seven data bits, both parity outcomes.
		for (int p = 1; p < 3; p++) for (int v = 0; v < 2; v++) begin
			apb(1'b1, `OFS_CFG, 32'h40 | (p << 4));
			send_chk(v ? 8'h01 : 8'h03, 1'b1, p[1:0]);
		end
		apb(1'b1, `OFS_CFG, 32'h8);
		check(e, 1'b1);
		apb(1'b1, `OFS_CFG, 32'h4008);
		check(e, 1'b0);
		bit_cyc = 32;
		// CTS off holds the character; RTS goes off while a character waits.
		check(rts_n, 1'b0);
		cts_n <= 1'b1;
		apb(1'b1, `OFS_TXD, 32'h96);
		repeat (300) @(posedge ref_clk);
		check(serial_term_i.nframes, nf);
		cts_n <= 1'b0;
		wait_frame;
		check(serial_term_i.frame, frm(8'h96, 1'b0, 2'h0));
		serial_term_i.send(8'hc3);
		check(rts_n, 1'b1);
		apb(1'b0, `OFS_RXD, 32'h0);
		check(q, 32'hc3);
		@(negedge ref_clk);
		check(rts_n, 1'b0);
		apb(1'b1, `OFS_CFG, 32'h0);
		bit_cyc = 64;
		serial_term_i.send(8'h5a);
		poll(`S_RXVALID, 1'b1);
		apb(1'b0, `OFS_RXD, 32'h0);
		check(q, 32'h5a);
		// An XOFF from the terminal holds the next character until XON.
		apb(1'b1, `OFS_CFG, 32'h2000);
		serial_term_i.send(`CHR_XOFF);
		poll(`S_PAUSED, 1'b1);
		apb(1'b1, `OFS_TXD, 32'h55);
		repeat (300) @(posedge ref_clk);
		check(serial_term_i.nframes, nf);
		serial_term_i.send(`CHR_XON);
		wait_frame;
		check(serial_term_i.frame, frm(8'h55, 1'b0, 2'h0));
		// Send mode: a stored character owes XOFF, reading it owes XON.
		apb(1'b1, `OFS_CFG, 32'h3c02_1000);
		serial_term_i.send(8'h3c);
		wait_frame;
		check(serial_term_i.frame, frm(`CHR_XOFF, 1'b0, 2'h0));
		poll(`S_TERM, 1'b1);
		apb(1'b0, `OFS_RXD, 32'h0);
		check(q, 32'h3c);
		wait_frame;
		check(serial_term_i.frame, frm(`CHR_XON, 1'b0, 2'h0));
		apb(1'b1, `OFS_STAT, 32'h10);
		apb(1'b0, `OFS_STAT, 32'h0);
		check(q[`S_TERM], 1'b0);
		// The line driver is released whenever nothing is left to send.
		apb(1'b1, `OFS_CFG, 32'h1_0000);
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		check(txd_oe_n, 1'b1);
		apb(1'b1, `OFS_TXD, 32'h0f);
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		check(txd_oe_n, 1'b0);
		wait_frame;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		check(txd_oe_n, 1'b1);
		finish_test;
	end
endmodule
`default_nettype wire
